// ===== include/las_pkg.sv
// Constants for the linear array scan sequencer.
// Assumes a 50 MHz system clock; all counts derive from it.
`default_nettype none
package las_pkg;
    localparam int unsigned SYS_HZ       = 50_000_000;
    localparam int unsigned US_PER_S     = 1_000_000;
    localparam int unsigned US_CYC       = SYS_HZ / US_PER_S;
    localparam int unsigned BURST_PULSES = 133;
    localparam int unsigned INTEG_START  = 18;
    localparam int unsigned POST_PULSES  = BURST_PULSES - INTEG_START;
    localparam int unsigned PIX_ELEMS    = 132;
    localparam int unsigned SEL_POS      = 16;
    // Edges after reset before synchronised selectors can be trusted
    localparam int unsigned SYNC_SETTLE  = 4;
    // Sensor clock rate per frequency selector position
    localparam int unsigned CLK_HZ [SEL_POS] = '{
        36_000, 64_000, 77_000, 93_000, 112_000, 141_000, 170_000, 214_000,
        284_000, 345_000, 435_000, 588_000, 909_000, 1_000_000, 1_250_000,
        1_670_000};
    // Positions 0..C: wait after the last pulse; D..F: total integration
    localparam int unsigned INTEG_US [SEL_POS] = '{
        10, 161, 311, 613, 916, 1231, 2431, 3031, 3781, 4531, 6031, 7631,
        9081, 10_500, 15_000, 20_000};
    localparam logic [3:0] FIX_FIRST = 4'hD;
    localparam logic [3:0] OOS_LO    = 4'h0;
    localparam logic [3:0] OOS_HI1   = 4'hE;
    localparam logic [3:0] OOS_HI2   = 4'hF;
    localparam logic [1:0] DONE_OK   = 2'h2;
    typedef enum logic [1:0] {
        LAS_LOAD  = 2'b00,
        LAS_SI    = 2'b01,
        LAS_BURST = 2'b11,
        LAS_WAIT  = 2'b10
    } las_state_t;
endpackage : las_pkg
`default_nettype wire

// ===== rtl/las_scan_seq.sv
// Scan-start and clock-burst generator for a 128-pixel linear array,
// with a pixel sample FIFO. Assumes selector switches on raw pins
// and an ADC on mclk that answers each pix_req.
// Summary of operation
// - Starts scanning automatically after reset
// - Clock rate follows 16-position frequency selector
// - Out-of-spec flag at positions 0, E, F
// - 133 pulses per scan, then clock low
// - Wait starts after 133rd pulse, then rescan
// - Totals from about 74us up to fixed 20ms
// - First scan after power-up only initialises
// - Clock may stop only after full burst; ce low freezes it mid-burst
// - Continuous scans at regular controlled intervals
// - Discard first two frames after reset
`timescale 1ns/10ps
`default_nettype none

module las_fifo #(
    parameter int unsigned W = 12,
    parameter int unsigned D = 16
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int unsigned AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    a_fifo_full: assert property (@(posedge mclk) disable iff (sys_rst)
        (!in_ready && !out_ready) |=> $stable(cnt_q))
        else $error("fifo full but count moved");
endmodule : las_fifo

module las_scan_seq #(
    parameter int unsigned DW        = 12,
    parameter int unsigned DEPTH     = 16,
    parameter int unsigned US_CYCLES = las_pkg::US_CYC
) (
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire logic          ce,
    input  wire logic [3:0]    fsel_pin,
    input  wire logic [3:0]    isel_pin,
    output logic               scan_start,
    output logic               sensor_clk,
    output logic               oos_led,
    output logic               frame_ok,
    output logic               pix_req,
    input  wire logic          adc_valid,
    output logic               adc_ready,
    input  wire logic [DW-1:0] adc_data,
    output logic               px_valid,
    input  wire logic          px_ready,
    output logic [DW-1:0]      px_data
);
    las_pkg::las_state_t st_q;
    logic [3:0]  fs1_q, fs2_q, fs3_q, fcur_q;
    logic [3:0]  is1_q, is2_q, is3_q, icur_q;
    logic [3:0]  fsel_q;
    logic [3:0]  isel_q;
    logic [15:0] half_q;
    logic [15:0] half_d;
    logic [15:0] hcnt_q;
    logic [7:0]  pcnt_q;
    logic [31:0] wcnt_q;
    logic [31:0] wait_d;
    logic [31:0] tgt;
    logic [31:0] burst_cyc;
    logic [1:0]  done_q;
    logic        si_q;
    logic        sclk_q;
    logic        oos_q;
    logic        req_q;
    logic        tick;
    logic        fall;

    // Three-stage pin sync; value accepted once stages two and three agree
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fs1_q <= 4'h0;
            fs2_q <= 4'h0;
            fs3_q <= 4'h0;
            fcur_q <= 4'h0;
        end else if (ce) begin
            fs1_q <= fsel_pin;
            fs2_q <= fs1_q;
            fs3_q <= fs2_q;
            if (fs2_q == fs3_q) begin
                fcur_q <= fs3_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            is1_q <= 4'h0;
            is2_q <= 4'h0;
            is3_q <= 4'h0;
            icur_q <= 4'h0;
        end else if (ce) begin
            is1_q <= isel_pin;
            is2_q <= is1_q;
            is3_q <= is2_q;
            if (is2_q == is3_q) begin
                icur_q <= is3_q;
            end
        end
    end

    // Half period lookup; rounding down keeps the rate at or just above nominal
    always_comb begin
        half_d = 16'h0001;
        for (int i = 0; i < las_pkg::SEL_POS; i++) begin
            if (fcur_q == 4'(i)) begin
                half_d = 16'(las_pkg::SYS_HZ / (2 * las_pkg::CLK_HZ[i]));
            end
        end
    end

    // Wait after the burst; top positions fix the total instead
    always_comb begin
        tgt = 32'h0000_0001;
        for (int i = 0; i < las_pkg::SEL_POS; i++) begin
            if (isel_q == 4'(i)) begin
                tgt = las_pkg::INTEG_US[i] * US_CYCLES;
            end
        end
        burst_cyc = 32'(las_pkg::POST_PULSES * 2) * {16'h0000, half_q};
        if (isel_q >= las_pkg::FIX_FIRST) begin
            wait_d = (tgt > burst_cyc) ? tgt - burst_cyc : 32'h0000_0001;
        end else begin
            wait_d = (tgt == 32'h0) ? 32'h0000_0001 : tgt;
        end
    end

    assign tick = (hcnt_q == 16'h0000);
    assign fall = (st_q == las_pkg::LAS_BURST) && tick && sclk_q;

    // Sequencer: LOAD samples settings, SI raises scan start, BURST, WAIT
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= las_pkg::LAS_LOAD;
            fsel_q <= 4'h0;
            isel_q <= 4'h0;
            half_q <= 16'h0001;
            hcnt_q <= 16'h0000;
            pcnt_q <= 8'h00;
            wcnt_q <= 32'(las_pkg::SYNC_SETTLE);
            si_q <= 1'b0;
            sclk_q <= 1'b0;
        end else if (ce) begin
            case (st_q)
                las_pkg::LAS_LOAD: begin
                    if (wcnt_q != 32'h0) begin // First scan waits for settled switches
                        wcnt_q <= wcnt_q - 32'h0000_0001;
                    end else begin
                        fsel_q <= fcur_q;
                        isel_q <= icur_q;
                        half_q <= half_d;
                        hcnt_q <= half_d - 16'h0001;
                        si_q <= 1'b1;
                        st_q <= las_pkg::LAS_SI;
                    end
                end
                las_pkg::LAS_SI: begin
                    // Setup half period before the first rising edge
                    if (tick) begin
                        sclk_q <= 1'b1;
                        hcnt_q <= half_q - 16'h0001;
                        pcnt_q <= 8'h00;
                        st_q <= las_pkg::LAS_BURST;
                    end else begin
                        hcnt_q <= hcnt_q - 16'h0001;
                    end
                end
                las_pkg::LAS_BURST: begin
                    if (tick) begin
                        sclk_q <= !sclk_q;
                        hcnt_q <= half_q - 16'h0001;
                        if (sclk_q) begin
                            si_q <= 1'b0;
                            pcnt_q <= pcnt_q + 8'h01;
                            if (pcnt_q == 8'(las_pkg::BURST_PULSES - 1)) begin
                                wcnt_q <= wait_d - 32'h0000_0001;
                                st_q <= las_pkg::LAS_WAIT;
                            end
                        end
                    end else begin
                        hcnt_q <= hcnt_q - 16'h0001;
                    end
                end
                las_pkg::LAS_WAIT: begin
                    // Clock stays low; fixed timing keeps every frame's exposure known
                    if (wcnt_q == 32'h0) begin
                        st_q <= las_pkg::LAS_LOAD;
                    end else begin
                        wcnt_q <= wcnt_q - 32'h0000_0001;
                    end
                end
                default: begin
                    st_q <= las_pkg::LAS_LOAD;
                end
            endcase
        end
    end

    // Out-of-spec indicator follows the live switch
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oos_q <= 1'b0;
        end else if (ce) begin
            oos_q <= (fcur_q == las_pkg::OOS_LO) || (fcur_q == las_pkg::OOS_HI1) ||
                     (fcur_q == las_pkg::OOS_HI2);
        end
    end

    // First burst only initialises, second carries unevenly timed data
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            done_q <= 2'h0;
        end else if (ce && fall && pcnt_q == 8'(las_pkg::BURST_PULSES - 1)) begin
            if (done_q != las_pkg::DONE_OK) begin
                done_q <= done_q + 2'h1;
            end
        end
    end

    // One sample request per element, on falling edges while it is stable
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            req_q <= 1'b0;
        end else if (ce) begin
            req_q <= fall && (pcnt_q < 8'(las_pkg::PIX_ELEMS));
        end
    end

    assign scan_start = si_q;
    assign sensor_clk = sclk_q;
    assign oos_led    = oos_q;
    assign pix_req    = req_q;
    assign frame_ok   = (done_q == las_pkg::DONE_OK);

    // Samples of discarded frames are dropped, not buffered
    las_fifo #(
        .W (DW),
        .D (DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (adc_valid && frame_ok),
        .in_ready  (adc_ready),
        .in_data   (adc_data),
        .out_valid (px_valid),
        .out_ready (px_ready),
        .out_data  (px_data)
    );

    a_start_auto: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == las_pkg::LAS_LOAD && ce && wcnt_q == 32'h0) |=> st_q == las_pkg::LAS_SI && si_q)
        else $error("scan did not start");
    a_half_map: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == las_pkg::LAS_LOAD && ce && wcnt_q == 32'h0) |=> half_q == $past(half_d))
        else $error("half period not taken");
    a_oos_map: assert property (@(posedge mclk) disable iff (sys_rst)
        ce |=> oos_q == ($past(fcur_q) inside {4'h0, 4'hE, 4'hF}))
        else $error("out of spec flag missing");
    a_burst_end: assert property (@(posedge mclk) disable iff (sys_rst)
        (ce && fall && pcnt_q == 8'h84) |=> st_q == las_pkg::LAS_WAIT && !sclk_q)
        else $error("burst did not end at 133");
    a_clk_idle: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q != las_pkg::LAS_BURST) |-> !sclk_q)
        else $error("clock high outside burst");
    a_si_setup: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(si_q) |-> !sclk_q ##1 (!sclk_q || st_q == las_pkg::LAS_BURST))
        else $error("scan start without setup");
    a_wait_end: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == las_pkg::LAS_WAIT && wcnt_q == 32'h0 && ce) |=>
        st_q == las_pkg::LAS_LOAD ##1 (si_q || !$past(ce)))
        else $error("wait expiry missed");
    a_sel_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q != las_pkg::LAS_LOAD) |=> $stable(fsel_q) && $stable(isel_q))
        else $error("selector changed mid scan");
    a_first_drop: assert property (@(posedge mclk) disable iff (sys_rst)
        !frame_ok |-> !px_valid)
        else $error("init frame accepted");
endmodule : las_scan_seq

`default_nettype wire

// ===== tb/las_sensor_model.sv
// Behavioural linear sensor: counts clock pulses per scan, answers pix_req.
// Assumes its pins are sampled on mclk, same domain as the sequencer.
`timescale 1ns/10ps
`default_nettype none

module las_sensor_model (
    input  wire logic   mclk,
    input  wire logic   sys_rst,
    input  wire logic   scan_start,
    input  wire logic   sensor_clk,
    input  wire logic   pix_req,
    output logic        adc_valid,
    output logic [11:0] adc_data,
    output int          short_scans,
    output int          integ
);
    logic clk_q;
    int   pulses;
    int   elem;

    always_ff @(posedge mclk) begin
        clk_q <= sensor_clk;
        if (sys_rst) begin
            pulses <= 133;
            short_scans <= 0;
        end else if (sensor_clk && !clk_q && scan_start) begin
            if (pulses != 133) short_scans <= short_scans + 1;
            pulses <= 1;
        end else if (sensor_clk && !clk_q) begin
            pulses <= pulses + 1;
        end
    end

    // Exposure runs from the 18th clock fall until scan start rises again
    always_ff @(posedge mclk) begin
        if (sys_rst || (sensor_clk && !clk_q && scan_start)) integ <= 0;
        else if (clk_q && !sensor_clk && pulses == 18) integ <= 1;
        else if (integ > 0 && !scan_start) integ <= integ + 1;
    end

    // Element 0 is the unconnected one, so it reads zero
    always_ff @(posedge mclk) begin
        if (sys_rst || scan_start) elem <= 0;
        else if (pix_req) elem <= elem + 1;
        adc_valid <= pix_req;
        // Released bus shows garbage: the last sample and its inverse in turn
        adc_data <= pix_req ? elem[11:0] : ~adc_data;
    end
endmodule : las_sensor_model

`default_nettype wire

// ===== tb/tb_las_scan_seq.sv
// Bench for the scan sequencer: burst timing, selectors, flag and FIFO.
// Assumes las_pkg is compiled first; waits shortened by US_CYCLES = 1.
`timescale 1ns/10ps
`default_nettype none

module tb_las_scan_seq;
    localparam int US = 1;
    logic        mclk;
    logic        sys_rst;
    logic        ce;
    logic [3:0]  fsel_pin;
    logic [3:0]  isel_pin;
    logic        scan_start;
    logic        sensor_clk;
    logic        oos_led;
    logic        frame_ok;
    logic        pix_req;
    logic        adc_valid;
    logic        adc_ready;
    logic [11:0] adc_data;
    logic        px_valid;
    logic        px_ready;
    logic [11:0] px_data;
    int          short_scans;
    int          integ;
    int          failures = 0;
    int          checked = 0;
    int          ss;
    int          h1;
    int          hl;
    int          np;
    int          gap;

    las_scan_seq #(.US_CYCLES(US)) i_las_scan_seq (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .fsel_pin(fsel_pin), .isel_pin(isel_pin), .scan_start(scan_start),
        .sensor_clk(sensor_clk), .oos_led(oos_led), .frame_ok(frame_ok), .pix_req(pix_req),
        .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_data(adc_data),
        .px_valid(px_valid), .px_ready(px_ready), .px_data(px_data));

    las_sensor_model i_las_sensor_model (.mclk(mclk), .sys_rst(sys_rst),
        .scan_start(scan_start), .sensor_clk(sensor_clk), .pix_req(pix_req),
        .adc_valid(adc_valid), .adc_data(adc_data), .short_scans(short_scans),
        .integ(integ));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic tick();
        @(negedge mclk);
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Runs from a scan start up to the next one; flips fsel mid-burst
    task automatic scan_cycle(input logic [3:0] f);
        logic pc;
        logic ps;
        int   n;
        pc = 1'b0;
        ps = 1'b1;
        ss = 1;
        h1 = 0;
        np = 0;
        gap = 0;
        n = 0;
        while (n < 20000) begin
            tick();
            n++;
            if (scan_start === 1'b1 && ps === 1'b0) break;
            if (scan_start === 1'b1) ss++;
            if (sensor_clk === 1'b1 && pc === 1'b0) begin
                np++;
                hl = 0;
            end
            if (sensor_clk === 1'b1) hl++;
            if (sensor_clk === 1'b1 && np == 1) h1++;
            gap = (sensor_clk === 1'b1) ? 0 : gap + 1;
            if (np == 60) fsel_pin = ~f;
            if (np == 100) fsel_pin = f;
            pc = sensor_clk;
            ps = scan_start;
        end
        if (n >= 20000) failures++;
    endtask : scan_cycle

    task automatic expect_scan(input int f, input int i);
        int h;
        int w;
        h = las_pkg::SYS_HZ / (2 * las_pkg::CLK_HZ[f]);
        w = las_pkg::INTEG_US[i] * US;
        if (i >= 13) w = (w > 230 * h) ? w - 230 * h : 1;
        check(h1, h);
        check(hl, h);
        check(np, 133);
        check(gap, w + 1);
        check(integ, w + 230 * h + 1);
    endtask : expect_scan

    task automatic t_first();
        repeat (5) tick();
        check(scan_start, 1'b1);
        check(frame_ok, 1'b0);
        scan_cycle(4'hF);
        expect_scan(15, 0);
        scan_cycle(4'hF);
        expect_scan(15, 0);
        check(frame_ok, 1'b1);
    endtask : t_first

    // Consumer stalls until full, then drains element by element
    task automatic t_fifo();
        int n;
        n = 0;
        while (adc_ready !== 1'b0 && n < 20000) begin
            tick();
            n++;
        end
        check(px_valid, 1'b1);
        px_ready = 1'b1;
        for (int k = 0; k < 16; k++) begin
            check(px_data, k);
            tick();
        end
        px_ready = 1'b0;
        check(adc_ready, 1'b1);
    endtask : t_fifo

    // First scan after a change may still use the old setting
    task automatic t_rate(input logic [3:0] f, input logic [3:0] i);
        fsel_pin = f;
        isel_pin = i;
        scan_cycle(f);
        scan_cycle(f);
        expect_scan(f, i);
        check(ss, 2 * (las_pkg::SYS_HZ / (2 * las_pkg::CLK_HZ[f])));
    endtask : t_rate

    // Enable low mid-burst must freeze the clock line for a whole half period
    task automatic t_freeze();
        logic c;
        c = sensor_clk;
        ce = 1'b0;
        repeat (las_pkg::SYS_HZ / (2 * las_pkg::CLK_HZ[11])) tick();
        check(sensor_clk, c);
        check(scan_start, 1'b0);
        ce = 1'b1;
    endtask : t_freeze

    // Short sweep inside one scan (setup half period, then early burst), so no slow setting gets sampled
    task automatic t_oos(input logic [3:0] f);
        for (int p = 0; p < 16; p++) begin
            fsel_pin = p[3:0];
            repeat (8) tick();
            check(oos_led, (p == 0 || p >= 14));
        end
        fsel_pin = f;
    endtask : t_oos

    task automatic results();
        $display("Checks %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    initial begin
        // About 60k cycles expected; margin of half again
        #1_800_000;
        failures++;
        results();
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        fsel_pin = 4'hF;
        isel_pin = 4'h0;
        px_ready = 1'b0;
        repeat (4) tick();
        sys_rst = 1'b0;
        t_first();
        t_fifo();
        t_rate(4'hE, 4'h5);
        t_rate(4'hD, 4'hD);
        t_rate(4'hB, 4'h0);
        t_oos(4'hB);
        t_freeze();
        check(short_scans, 0);
        results();
    end
endmodule : tb_las_scan_seq

`default_nettype wire
